// >>> include/tmr_pkg.sv
// package for the 8-bit single compare timer: map, fields, types
package tmr_pkg;
	// register byte addresses on the wishbone bus
	localparam logic [3:0] ADDR_CTRL    = 4'h0; // mode, compare action, source
	localparam logic [3:0] ADDR_COUNT   = 4'h4; // counter value
	localparam logic [3:0] ADDR_COMPARE = 4'h8; // compare value
	localparam logic [3:0] ADDR_FLAG    = 4'hc; // timer flag register
	localparam logic [4:0] ADDR_MASK    = 5'h10; // timer mask register
	localparam logic [4:0] ADDR_FORCE   = 5'h14; // force compare strobe
	localparam int         ADDR_W       = 5;

	// field positions
	localparam int CTRL_CS_LSB  = 0; // clock select, 3 bits
	localparam int CTRL_WGM_LSB = 3; // waveform mode, 2 bits
	localparam int CTRL_COM_LSB = 5; // compare output action, 2 bits
	localparam int FLAG_OVF     = 0; // overflow flag bit
	localparam int FLAG_CMP     = 1; // compare flag bit

	// count limits
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;
	localparam logic [7:0] RST_BYTE   = 8'h00;

	// prescaler width
	localparam int PRESC_W = 10;

	// clock select codes
	typedef enum logic [2:0] {
		CS_STOP   = 3'h0,
		CS_DIV1   = 3'h1,
		CS_DIV8   = 3'h2,
		CS_DIV64  = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1K  = 3'h5,
		CS_EXTF   = 3'h6,
		CS_EXTR   = 3'h7
	} tmr_cs_t;

	// waveform generation modes
	typedef enum logic [1:0] {
		WGM_NORMAL = 2'h0,
		WGM_PHASE  = 2'h1,
		WGM_CLRMAT = 2'h2,
		WGM_FAST   = 2'h3
	} tmr_wgm_t;

	// control register layout
	typedef struct packed {
		logic [1:0] com;
		tmr_wgm_t   wgm;
		tmr_cs_t    cs;
	} tmr_ctrl_t;

	// classic wishbone request bundle
	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [3:0]        sel;
		logic [ADDR_W-1:0] adr;
		logic [31:0]       dat;
	} tmr_wb_req_t;
endpackage

// >>> rtl/tmr_sync2.sv
// two flop synchroniser for the external count pin
`timescale 1ns/1ps
module tmr_sync2 (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);
	logic meta_q; // first stage, read only by the second

	// plain two stage crossing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule // tmr_sync2

// >>> rtl/tmr_tick_sel.sv
// clock select: prescaler taps and external edge into one tick
`timescale 1ns/1ps
module tmr_tick_sel
	import tmr_pkg::*;
#(
	parameter int PW = PRESC_W
) (
	input  wire logic    clk,
	input  wire logic    rst,
	input  wire tmr_cs_t cs,
	input  wire logic    extSync,
	output logic         tick
);
	logic [PW-1:0] presc_q; // free running prescaler
	logic          extPrev_q; // last synchronised pin level
	logic          tapHit; // selected prescaler tap reached
	logic          rise;
	logic          fall;

	// prescaler runs always; the 10-bit counter gives div 1024
	always_ff @(posedge clk or posedge rst) begin
		if (rst) presc_q <= '0;
		else     presc_q <= presc_q + 1'b1;
	end

	// edge history of the already synchronised pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) extPrev_q <= 1'b0;
		else     extPrev_q <= extSync;
	end

	assign rise = extSync & ~extPrev_q;
	assign fall = ~extSync & extPrev_q;

	// tap decode: a division hits when the low bits are all ones, just before they wrap
	always_comb begin
		unique case (cs)
			CS_DIV8:   tapHit = (presc_q[2:0] == 3'h7);
			CS_DIV64:  tapHit = (presc_q[5:0] == 6'h3f);
			CS_DIV256: tapHit = (presc_q[7:0] == 8'hff);
			CS_DIV1K:  tapHit = (presc_q == '1);
			default:   tapHit = 1'b1;
		endcase
	end

	// source and edge choice; stop yields no tick at all
	always_comb begin
		unique case (cs)
			CS_STOP: tick = 1'b0;
			CS_EXTF: tick = fall;
			CS_EXTR: tick = rise;
			default: tick = tapHit;
		endcase
	end

	a_stop_no_tick: assert property (@(posedge clk) disable iff (rst)
		(cs == CS_STOP) |-> !tick)
		else $error("tick while clock select is stop");
	a_ext_rise_tick: assert property (@(posedge clk) disable iff (rst)
		(cs == CS_EXTR && tick) |-> (extSync && !$past(extSync)))
		else $error("rising tick without rising pin");
endmodule // tmr_tick_sel

// >>> rtl/tmr_timer8.sv
// 8-bit timer with one compare unit, wishbone register slave
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module tmr_timer8
	import tmr_pkg::*;
#(
	parameter int CW = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire tmr_wb_req_t       wbReq,
	output logic [31:0]            wbDatO,
	output logic                   wbAck,
	input  wire logic              extCountPin,
	output logic                   compareOutPin,
	output logic                   compareOutEn,
	output logic [1:0]             irqReq
);
	tmr_ctrl_t     ctrl_q; // mode, action, source
	logic [CW-1:0] count_q; // counter value
	logic [CW-1:0] cmpBuf_q; // cpu side compare buffer
	logic [CW-1:0] cmpAct_q; // compare value in use
	logic [1:0]    flag_q; // overflow and compare flags
	logic [1:0]    mask_q; // per source enables
	logic          down_q; // phase pwm direction
	logic          block_q; // match blocked after count write
	logic          matchPrev_q; // match seen, flag on next tick
	logic          oc_q; // internal compare output state
	logic          extSync; // synchronised pin
	logic          tick; // timer tick
	logic          wbWr; // accepted write strobe this cycle
	logic          wbRd;
	logic          match; // comparator
	logic          pwmMode;
	logic [CW-1:0] top; // active top
	logic          atTop;
	logic          atBottom;
	logic          ovfEvt;
	logic          cmpEvt;
	logic          forceHit;
	logic          cmpHit; // unblocked match now or since last tick

	// pin crossing then clock select
	tmr_sync2 u_sync (
		.clk (clk),
		.rst (rst),
		.din (extCountPin),
		.dout(extSync)
	);

	tmr_tick_sel #(.PW(PRESC_W)) u_tick (
		.clk    (clk),
		.rst    (rst),
		.cs     (ctrl_q.cs),
		.extSync(extSync),
		.tick   (tick)
	);

	// bus strobes: one access per cycle with ack low, ack next cycle
	assign wbWr = wbReq.cyc & wbReq.stb & wbReq.we & ~wbAck & wbReq.sel[0];
	assign wbRd = wbReq.cyc & wbReq.stb & ~wbReq.we & ~wbAck;

	// mode decode and limits
	assign pwmMode  = (ctrl_q.wgm == WGM_PHASE) || (ctrl_q.wgm == WGM_FAST);
	assign top      = (ctrl_q.wgm == WGM_CLRMAT) ? cmpAct_q : CNT_MAX;
	assign atTop    = (count_q == top);
	assign atBottom = (count_q == CNT_BOTTOM);
	assign match    = (count_q == cmpAct_q);
	assign forceHit = wbWr && (wbReq.adr == ADDR_FORCE) && !pwmMode
		&& wbReq.dat[0];

	// overflow event: max in free modes; phase pwm term needs bottom with down_q set, which is cleared at count 1
	always_comb begin
		unique case (ctrl_q.wgm)
			WGM_PHASE: ovfEvt = tick && atBottom && down_q;
			WGM_CLRMAT: ovfEvt = tick && (count_q == CNT_MAX);
			default:   ovfEvt = tick && (count_q == CNT_MAX);
		endcase
	end

	// a match flagged at the tick that leaves the match value; the live
	// term covers div 1, where the match cycle is itself a tick cycle
	assign cmpHit = matchPrev_q || (match && !block_q);
	assign cmpEvt = tick && cmpHit;

	// control register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) ctrl_q <= '0;
		else if (wbWr && wbReq.adr == {1'b0, ADDR_CTRL})
			ctrl_q <= tmr_ctrl_t'(wbReq.dat[7:0]);
	end

	// counter: cpu write first, then clear, then count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= RST_BYTE;
		end else if (wbWr && wbReq.adr == {1'b0, ADDR_COUNT}) begin
			count_q <= wbReq.dat[CW-1:0];
		end else if (tick) begin
			if (ctrl_q.wgm == WGM_PHASE) begin
				// up to max then down to bottom
				if (down_q) count_q <= count_q - 1'b1;
				else        count_q <= count_q + 1'b1;
			end else if (ctrl_q.wgm == WGM_CLRMAT && atTop) begin
				count_q <= CNT_BOTTOM;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end

	// phase pwm direction turns at max and bottom
	always_ff @(posedge clk or posedge rst) begin
		if (rst) down_q <= 1'b0;
		else if (ctrl_q.wgm != WGM_PHASE) down_q <= 1'b0;
		else if (tick && count_q == CNT_MAX - 8'h01 && !down_q) down_q <= 1'b1;
		else if (tick && count_q == CNT_BOTTOM + 8'h01 && down_q) down_q <= 1'b0;
	end

	// compare buffer and the value in use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmpBuf_q <= RST_BYTE;
			cmpAct_q <= RST_BYTE;
		end else begin
			if (wbWr && wbReq.adr == {1'b0, ADDR_COMPARE})
				cmpBuf_q <= wbReq.dat[CW-1:0];
			if (!pwmMode) begin
				// direct path so writes act at once
				if (wbWr && wbReq.adr == {1'b0, ADDR_COMPARE})
					cmpAct_q <= wbReq.dat[CW-1:0];
			end else if (tick && ((ctrl_q.wgm == WGM_FAST && atTop) ||
					(ctrl_q.wgm == WGM_PHASE && count_q == CNT_MAX))) begin
				// update only at top: no odd length pulses
				cmpAct_q <= cmpBuf_q;
			end
		end
	end

	// a count write blocks the match for the next timer tick
	always_ff @(posedge clk or posedge rst) begin
		if (rst) block_q <= 1'b0;
		else if (wbWr && wbReq.adr == {1'b0, ADDR_COUNT}) block_q <= 1'b1;
		else if (tick) block_q <= 1'b0;
	end

	// remember match seen between ticks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) matchPrev_q <= 1'b0;
		else if (tick) matchPrev_q <= 1'b0;
		else if (match && !block_q) matchPrev_q <= 1'b1;
	end

	// flags: hardware set wins over write one to clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == FLAG_OVF && ovfEvt) || (i == FLAG_CMP && cmpEvt))
					flag_q[i] <= 1'b1;
				else if (wbWr && wbReq.adr == ADDR_FLAG && wbReq.dat[i])
					flag_q[i] <= 1'b0;
			end
		end
	end

	// mask register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) mask_q <= 2'h0;
		else if (wbWr && wbReq.adr == ADDR_MASK) mask_q <= wbReq.dat[1:0];
	end

	// masked requests, registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) irqReq <= 2'h0;
		else     irqReq <= flag_q & mask_q;
	end

	// waveform generator on the compare result
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc_q <= 1'b0;
		end else if (forceHit || (cmpEvt && !pwmMode)) begin
			// non pwm: toggle, clear or set on match
			unique case (ctrl_q.com)
				2'h1:    oc_q <= ~oc_q;
				2'h2:    oc_q <= 1'b0;
				2'h3:    oc_q <= 1'b1;
				default: oc_q <= oc_q;
			endcase
		end else if (pwmMode && tick && ctrl_q.com[1]) begin
			// pwm: output follows count below compare
			if (ctrl_q.wgm == WGM_FAST && atTop)
				oc_q <= ~ctrl_q.com[0];
			else if (cmpHit)
				oc_q <= (ctrl_q.wgm == WGM_PHASE) ?
					(ctrl_q.com[0] ^ down_q) : ctrl_q.com[0];
		end
	end

	// pin drive from the registered output state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compareOutPin <= 1'b0;
			compareOutEn  <= 1'b0;
		end else begin
			compareOutPin <= oc_q;
			compareOutEn  <= (ctrl_q.com != 2'h0);
		end
	end

	// bus answer: one cycle ack, zero for unmapped reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wbAck  <= 1'b0;
			wbDatO <= '0;
		end else begin
			wbAck <= wbReq.cyc & wbReq.stb & ~wbAck;
			if (wbRd) begin
				unique case (wbReq.adr)
					{1'b0, ADDR_CTRL}:    wbDatO <= {24'h0, ctrl_q};
					{1'b0, ADDR_COUNT}:   wbDatO <= {24'h0, count_q};
					{1'b0, ADDR_COMPARE}: wbDatO <= {24'h0, cmpBuf_q};
					{1'b0, ADDR_FLAG}:    wbDatO <= {30'h0, flag_q};
					ADDR_MASK:            wbDatO <= {30'h0, mask_q};
					default:              wbDatO <= '0;
				endcase
			end
		end
	end

	a_flag_set_wins: assert property (@(posedge clk) disable iff (rst)
		cmpEvt |=> flag_q[FLAG_CMP])
		else $error("compare flag missed its event");
	a_flag_w1c: assert property (@(posedge clk) disable iff (rst)
		(wbWr && wbReq.adr == ADDR_FLAG && wbReq.dat[FLAG_CMP] && !cmpEvt)
		|=> !flag_q[FLAG_CMP])
		else $error("compare flag not cleared by write one");
	a_cnt_write_prio: assert property (@(posedge clk) disable iff (rst)
		(wbWr && wbReq.adr == {1'b0, ADDR_COUNT})
		|=> count_q == $past(wbReq.dat[7:0]))
		else $error("count write lost");
	a_stop_hold: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q.cs == CS_STOP && !wbWr) |=> $stable(count_q))
		else $error("counter moved while stopped");
	a_clr_match: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q.wgm == WGM_CLRMAT && tick && atTop && !wbWr)
		|=> count_q == CNT_BOTTOM)
		else $error("no reload on match");
	a_direct_cmp: assert property (@(posedge clk) disable iff (rst)
		(!pwmMode && wbWr && wbReq.adr == {1'b0, ADDR_COMPARE})
		|=> cmpAct_q == $past(wbReq.dat[7:0]))
		else $error("compare not direct outside pwm");
	a_buf_hold: assert property (@(posedge clk) disable iff (rst)
		(pwmMode && !tick && $past(pwmMode)) |=> $stable(cmpAct_q))
		else $error("compare in use changed off top");
	a_irq_gate: assert property (@(posedge clk) disable iff (rst)
		irqReq == $past(flag_q & mask_q))
		else $error("request not gated by mask");
	a_ovf_max: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q.wgm == WGM_NORMAL && tick && count_q == CNT_MAX && !wbWr)
		|=> flag_q[FLAG_OVF] && count_q == CNT_BOTTOM)
		else $error("overflow at max not flagged");
endmodule // tmr_timer8

// >>> verification/tmr_cpu_model.sv
// cpu side model: classic wishbone master issuing single cycles
`timescale 1ns/1ps
module tmr_cpu_model
	import tmr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        wbAck,
	input  wire logic [31:0] wbDatO,
	output tmr_wb_req_t      wbReq
);
	// idle bus at time zero
	initial begin
		wbReq = '0;
	end

	// one bus cycle; request held until ack is sampled high
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
			input logic [7:0] d, output logic [31:0] q);
		@(posedge clk);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a,
			dat: {24'h000000, d}};
		do @(posedge clk); while (wbAck !== 1'b1);
		q = wbDatO;
		wbReq.cyc <= 1'b0;
		wbReq.stb <= 1'b0;
		// released data lines do not keep the last value
		wbReq.dat <= ~wbReq.dat;
	endtask

	// byte write
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	// word read
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
		xfer(1'b0, a, 8'h00, q);
	endtask
endmodule // tmr_cpu_model

// >>> verification/tmr_timer8_tb.sv
// self-checking bench for the 8-bit single compare timer
`timescale 1ns/1ps
module tmr_timer8_tb
	import tmr_pkg::*;
;
	logic        clk;           // system clock
	logic        rst;           // async reset
	tmr_wb_req_t wbReq;         // bus request from cpu model
	logic [31:0] wbDatO;        // read data
	logic        wbAck;         // bus ack
	logic        extCountPin;   // external count input
	logic        compareOutPin; // waveform output
	logic        compareOutEn;  // waveform output enable
	logic [1:0]  irqReq;        // interrupt requests
	logic [31:0] v;             // scratch read value
	int          nMismatch = 0;
	int          nTests = 0;

	tmr_timer8 i_dut (.clk(clk), .rst(rst), .wbReq(wbReq),
		.wbDatO(wbDatO), .wbAck(wbAck), .extCountPin(extCountPin),
		.compareOutPin(compareOutPin), .compareOutEn(compareOutEn),
		.irqReq(irqReq));

	tmr_cpu_model i_cpu (.clk(clk), .wbAck(wbAck), .wbDatO(wbDatO),
		.wbReq(wbReq));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			nMismatch++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// read a register and compare
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		i_cpu.rd(a, v);
		chk(v, e);
	endtask

	// n full pulses on the external pin, slow enough for the sync stage
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk) extCountPin <= 1'b1;
			repeat (4) @(posedge clk);
			extCountPin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	// registers come up zero, unmapped read gives zero
	task automatic t_reset;
		chk({29'h0, irqReq, compareOutEn}, 32'h0);
		rdc(5'(ADDR_CTRL), 32'h0);
		rdc(5'(ADDR_COUNT), 32'h0);
		rdc(5'(ADDR_COMPARE), 32'h0);
		rdc(ADDR_FLAG, 32'h0);
		rdc(ADDR_MASK, 32'h0);
		rdc(5'h18, 32'h0);
	endtask

	// stopped counter keeps written value; only 8 bits stored
	task automatic t_halt;
		i_cpu.wr(5'(ADDR_COUNT), 8'hab);
		repeat (20) @(posedge clk);
		rdc(5'(ADDR_COUNT), 32'hab);
		i_cpu.wr(5'(ADDR_COMPARE), 8'hff);
		rdc(5'(ADDR_COMPARE), 32'hff);
	endtask

	// run past compare and max, then flags, masks and clearing
	task automatic t_flags;
		i_cpu.wr(5'(ADDR_COMPARE), 8'hf8);
		i_cpu.wr(5'(ADDR_COUNT), 8'hf0);
		i_cpu.wr(5'(ADDR_CTRL), 8'h01);
		repeat (40) @(posedge clk);
		i_cpu.wr(5'(ADDR_CTRL), 8'h00);
		rdc(ADDR_FLAG, 32'h3);
		repeat (3) @(posedge clk);
		chk({30'h0, irqReq}, 32'h0);
		i_cpu.wr(ADDR_MASK, 8'h02);
		repeat (3) @(posedge clk);
		chk({30'h0, irqReq}, 32'h2);
		i_cpu.wr(ADDR_MASK, 8'h03);
		repeat (3) @(posedge clk);
		chk({30'h0, irqReq}, 32'h3);
		i_cpu.wr(ADDR_FLAG, 8'h00);
		rdc(ADDR_FLAG, 32'h3);
		i_cpu.wr(ADDR_FLAG, 8'h01);
		rdc(ADDR_FLAG, 32'h2);
		chk({30'h0, irqReq}, 32'h2);
		i_cpu.wr(ADDR_FLAG, 8'h02);
		rdc(ADDR_FLAG, 32'h0);
		i_cpu.wr(ADDR_MASK, 8'h00);
	endtask

	// divide by 8 tap: about 82 cycles give 10 or 11 ticks
	task automatic t_presc;
		i_cpu.wr(5'(ADDR_COUNT), 8'h00);
		i_cpu.wr(5'(ADDR_CTRL), 8'h02);
		repeat (80) @(posedge clk);
		i_cpu.wr(5'(ADDR_CTRL), 8'h00);
		i_cpu.rd(5'(ADDR_COUNT), v);
		chk({31'h0, v inside {[32'h9 : 32'hb]}}, 32'h1);
	endtask

	// clear on match with toggle: count stays at or below compare
	task automatic t_ctc;
		i_cpu.wr(5'(ADDR_COUNT), 8'h00);
		i_cpu.wr(5'(ADDR_COMPARE), 8'h05);
		i_cpu.wr(5'(ADDR_CTRL), 8'h31);
		repeat (8) begin
			i_cpu.rd(5'(ADDR_COUNT), v);
			chk({31'h0, v <= 32'h5}, 32'h1);
		end
		// period of six ticks: one toggle in any six-cycle span
		@(posedge clk) #1 v[0] = compareOutPin;
		repeat (6) @(posedge clk);
		#1 chk({30'h0, compareOutEn, compareOutPin != v[0]}, 32'h3);
		i_cpu.wr(5'(ADDR_CTRL), 8'h00);
	endtask

	// forced compare sets then clears the output
	task automatic t_force;
		i_cpu.wr(5'(ADDR_CTRL), 8'h60);
		i_cpu.wr(ADDR_FORCE, 8'h01);
		repeat (2) @(posedge clk);
		chk({31'h0, compareOutPin}, 32'h1);
		i_cpu.wr(5'(ADDR_CTRL), 8'h40);
		i_cpu.wr(ADDR_FORCE, 8'h01);
		repeat (2) @(posedge clk);
		chk({31'h0, compareOutPin}, 32'h0);
		i_cpu.wr(5'(ADDR_CTRL), 8'h00);
	endtask

	// fast pwm, non-inverting, div 1: high from bottom through 0x40,
	// so any 256-cycle window holds 0x41 high cycles
	task automatic t_pwm;
		int nHigh;
		nHigh = 0;
		i_cpu.wr(5'(ADDR_COMPARE), 8'h40);
		i_cpu.wr(5'(ADDR_COUNT), 8'h00);
		i_cpu.wr(5'(ADDR_CTRL), 8'h59);
		repeat (300) @(posedge clk);
		repeat (256) begin
			@(posedge clk);
			nHigh += int'(compareOutPin);
		end
		chk(32'(nHigh), 32'h41);
		i_cpu.wr(5'(ADDR_CTRL), 8'h00);
	endtask

	// external pin: rising then falling edge selection
	task automatic t_ext;
		i_cpu.wr(5'(ADDR_CTRL), 8'h07);
		i_cpu.wr(5'(ADDR_COUNT), 8'h00);
		pulses(3);
		repeat (6) @(posedge clk);
		rdc(5'(ADDR_COUNT), 32'h3);
		i_cpu.wr(5'(ADDR_CTRL), 8'h06);
		i_cpu.wr(5'(ADDR_COUNT), 8'h00);
		pulses(2);
		repeat (6) @(posedge clk);
		rdc(5'(ADDR_COUNT), 32'h2);
		i_cpu.wr(5'(ADDR_CTRL), 8'h00);
	endtask

	// single place where the run ends
	task automatic give_verdict;
		if (nMismatch == 0 && nTests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// watchdog well beyond the roughly one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		give_verdict();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		extCountPin = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_halt();
		t_flags();
		t_presc();
		t_ctc();
		t_force();
		t_pwm();
		t_ext();
		give_verdict();
	end
endmodule // tmr_timer8_tb
